// ---- logic/sbff_unit.sv ----
// apb-mapped subword extract/insert/compare, boolean and float format unit
`timescale 1ns/1ps
`include "sbff_params.svh"

// How it works
// - byte_order_select picks left-to-right or right-to-left lanes for bytes and halves.
// - byte store with data width enable replicates low byte into all four lanes.
// - half store with data width enable replicates low half into both lanes.
// - signed byte and half use their own top bit as the sign.
// - extract byte replaces only destination low byte with the selected source byte.
// - insert byte writes source low byte, or instruction constant, into selected lane.
// - compare bytes gives true when any of the four byte pairs match.
// - extract half replaces destination low half with source low or high half.
// - signed extract half fills the upper sixteen bits with the half's sign.
// - insert half writes source low half into destination low or high half.
// - boolean lives in bit 31; branch test looks at that bit only.
// - compare results clear every bit except the top one.
// - float operations are not computed here but raised for software emulation.
// - nan means exponent all ones and nonzero fraction, sign ignored.
// - fraction top bit one means quiet nan, zero means signaling.
// - signaling nan input raises invalid operation; quiet nan does not.
// - no result is ever a signaling nan; nans only from invalid or nan input.
// - every generated nan carries fraction with top two bits set, rest clear.
// - reserved operand enable turns a nan outcome into a float exception trap.
// - the two-bit byte pointer chooses the lane for insert and extract.
// - byte or half load with data width enable sign-extends when sign flag set, else zero-extends.
module sbff_unit
    import sbff_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fp_emulate_req,
    output logic             fp_exc_trap
);

    sbff_state_t st_r;
    sbff_state_t st_nxt;

    // physical lane of the pointed byte; bp 0 is the leftmost byte in left-to-right order
    function automatic logic [1:0] byte_lane(input logic bo, input logic [1:0] bp);
        byte_lane = bo ? (2'h3 - bp) : bp;
    endfunction : byte_lane

    function automatic logic half_lane(input logic bo, input logic [1:0] bp);
        half_lane = bo ? ~bp[1] : bp[1];
    endfunction : half_lane

    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] ln);
        get_byte = w[ln*8 +: 8];
    endfunction : get_byte

    function automatic logic [15:0] get_half(input logic [31:0] w, input logic ln);
        get_half = ln ? w[31:16] : w[15:0];
    endfunction : get_half

    function automatic logic [31:0] ext_byte(input logic [7:0] b, input logic sgn);
        ext_byte = {{24{sgn & b[7]}}, b};
    endfunction : ext_byte

    function automatic logic [31:0] ext_half(input logic [15:0] h, input logic sgn);
        ext_half = {{16{sgn & h[15]}}, h};
    endfunction : ext_half

    logic        acc;
    logic        wr;
    logic        mapped;
    logic        hit_cfg;
    logic        hit_bp;
    logic        hit_a;
    logic        hit_b;
    logic        hit_cmd;
    logic        hit_stat;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    sbff_cmd_t   cmd;
    sbff_stat_t  set_v;
    sbff_stat_t  clr_v;
    sbff_stat_t  live_v;
    logic        live_en;
    logic [31:0] res_v;
    logic [31:0] res_lo_v;
    logic        res_en;
    logic [1:0]  bl;
    logic        hl;
    logic [7:0]  src_byte;
    logic        any_eq;
    logic        a_nan;
    logic        a_quiet;
    logic        b_nan;
    logic        b_quiet;
    logic        d_nan;
    logic        d_quiet;
    logic        nan_in;
    logic        snan_in;
    logic        qnan_in;
    logic        nan_out;

    always_comb begin
        acc      = psel & penable & ~st_r.pready;
        wr       = psel & penable & st_r.pready & pwrite;
        hit_cfg  = (paddr == `SBFF_OFF_CONFIG);
        hit_bp   = (paddr == `SBFF_OFF_BYTE_PTR);
        hit_a    = (paddr == `SBFF_OFF_OPER_A);
        hit_b    = (paddr == `SBFF_OFF_OPER_B);
        hit_cmd  = (paddr == `SBFF_OFF_COMMAND);
        hit_stat = (paddr == `SBFF_OFF_STATUS);
        mapped   = hit_cfg | hit_bp | hit_a | hit_b | hit_cmd | hit_stat
                 | (paddr == `SBFF_OFF_RESULT) | (paddr == `SBFF_OFF_RESULT_LO);
        wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        // bit 7 of the command word is unused; drop it so imm and pair fields sit on byte lanes
        cmd      = sbff_cmd_t'({pwdata[23:8], pwdata[6:0]});
        bl       = byte_lane(st_r.cfg.byte_order_select, st_r.byte_pointer);
        hl       = half_lane(st_r.cfg.byte_order_select, st_r.byte_pointer);
        // float fields: singles in oper_a and oper_b, double hi in oper_a and lo in oper_b
        a_nan    = (st_r.oper_a[30:23] == `SBFF_SP_EXP_ONES)
                 & (st_r.oper_a[22:0] != 23'h000000);
        a_quiet  = st_r.oper_a[22];
        b_nan    = (st_r.oper_b[30:23] == `SBFF_SP_EXP_ONES)
                 & (st_r.oper_b[22:0] != 23'h000000);
        b_quiet  = st_r.oper_b[22];
        d_nan    = (st_r.oper_a[30:20] == `SBFF_DP_EXP_ONES)
                 & ({st_r.oper_a[19:0], st_r.oper_b} != 52'h0);
        d_quiet  = st_r.oper_a[19];
        any_eq   = 1'b0;
        for (int i = 0; i < 4; i++) begin
            any_eq = any_eq | (st_r.oper_a[i*8 +: 8] == st_r.oper_b[i*8 +: 8]);
        end
        set_v    = sbff_stat_t'(`SBFF_STAT_RESET);
        clr_v    = sbff_stat_t'(`SBFF_STAT_RESET);
        live_v   = st_r.stat;
        live_en  = 1'b0;
        res_v    = st_r.result;
        res_lo_v = st_r.result_lo;
        res_en   = 1'b0;
        src_byte = 8'h00;
        nan_in   = 1'b0;
        snan_in  = 1'b0;
        qnan_in  = 1'b0;
        nan_out  = 1'b0;

        if (wr && hit_cmd && pstrb[0]) begin
            res_en        = 1'b1;
            live_en       = 1'b1;
            set_v.done    = 1'b1;
            live_v.is_nan = 1'b0;
            live_v.quiet  = 1'b0;
            live_v.signaling   = 1'b0;
            live_v.branch_true = 1'b0;
            live_v.pair_misaligned = 1'b0;
            src_byte = cmd.imm_sel ? cmd.imm_byte : st_r.oper_b[7:0];
            case (cmd.opcode)
                `SBFF_OP_EXTRACT_BYTE_OP: begin
                    // oper_b is the destination, so zero there zero-extends
                    res_v = {st_r.oper_b[31:8], get_byte(st_r.oper_a, bl)};
                end
                `SBFF_OP_INSERT_BYTE_OP: begin
                    res_v = st_r.oper_a;
                    res_v[bl*8 +: 8] = src_byte;
                end
                `SBFF_OP_COMPARE_BYTES_OP: begin
                    res_v = {any_eq, 31'h00000000};
                end
                `SBFF_OP_EXHALF: begin
                    res_v = {st_r.oper_b[31:16], get_half(st_r.oper_a, hl)};
                end
                `SBFF_OP_EXHALF_S: begin
                    res_v = ext_half(get_half(st_r.oper_a, hl), 1'b1);
                end
                `SBFF_OP_INHALF: begin
                    res_v = hl ? {st_r.oper_b[15:0], st_r.oper_a[15:0]}
                               : {st_r.oper_a[31:16], st_r.oper_b[15:0]};
                end
                `SBFF_OP_STORE_B: begin
                    // without width enable the store is a plain word
                    res_v = st_r.cfg.data_width_enable ? {4{st_r.oper_a[7:0]}}
                                                      : st_r.oper_a;
                end
                `SBFF_OP_STORE_H: begin
                    res_v = st_r.cfg.data_width_enable ? {2{st_r.oper_a[15:0]}}
                                                      : st_r.oper_a;
                end
                `SBFF_OP_LOAD_B: begin
                    res_v = st_r.cfg.data_width_enable
                          ? ext_byte(get_byte(st_r.oper_b, bl), cmd.sign_flag)
                          : st_r.oper_b;
                end
                `SBFF_OP_LOAD_H: begin
                    res_v = st_r.cfg.data_width_enable
                          ? ext_half(get_half(st_r.oper_b, hl), cmd.sign_flag)
                          : st_r.oper_b;
                end
                `SBFF_OP_FP_SINGLE, `SBFF_OP_FP_DOUBLE: begin
                    if (cmd.opcode == `SBFF_OP_FP_DOUBLE) begin
                        nan_in  = d_nan;
                        snan_in = d_nan & ~d_quiet;
                        qnan_in = d_nan & d_quiet;
                        // odd first register makes the pair unusable
                        live_v.pair_misaligned = cmd.pair_reg[0];
                    end else begin
                        nan_in  = a_nan | b_nan;
                        snan_in = (a_nan & ~a_quiet) | (b_nan & ~b_quiet);
                        qnan_in = (a_nan & a_quiet) | (b_nan & b_quiet);
                    end
                    nan_out            = nan_in | cmd.invalid_req;
                    live_v.is_nan      = nan_in;
                    live_v.quiet       = qnan_in;
                    live_v.signaling   = snan_in;
                    set_v.fp_emulate   = 1'b1;
                    set_v.invalid_op   = snan_in | cmd.invalid_req;
                    set_v.fp_exc_trap  = nan_out & st_r.cfg.fp_trap_en;
                    // arithmetic is software's; only the default quiet nan is formed here
                    if (nan_out) begin
                        if (cmd.opcode == `SBFF_OP_FP_DOUBLE) begin
                            res_v    = `SBFF_DP_GEN_NAN_HI;
                            res_lo_v = `SBFF_DP_GEN_NAN_LO;
                        end else begin
                            res_v    = `SBFF_SP_GEN_NAN;
                        end
                    end
                end
                `SBFF_OP_BRANCH: begin
                    live_v.branch_true = st_r.oper_a[31];
                end
                default: begin
                    res_v = st_r.result;
                end
            endcase
        end
        if (wr && hit_stat) begin
            clr_v = sbff_stat_t'(pwdata[8:0] & `SBFF_STICKY_MASK | {8'h00, pwdata[0]});
        end

        case (paddr)
            `SBFF_OFF_CONFIG:    rd_word = {29'h00000000, st_r.cfg};
            `SBFF_OFF_BYTE_PTR:  rd_word = {30'h00000000, st_r.byte_pointer};
            `SBFF_OFF_OPER_A:    rd_word = st_r.oper_a;
            `SBFF_OFF_OPER_B:    rd_word = st_r.oper_b;
            `SBFF_OFF_RESULT:    rd_word = st_r.result;
            `SBFF_OFF_STATUS:    rd_word = {23'h000000, st_r.stat};
            `SBFF_OFF_RESULT_LO: rd_word = st_r.result_lo;
            default:             rd_word = 32'h00000000;
        endcase

        st_nxt        = st_r;
        st_nxt.pready = acc;
        if (acc) begin
            st_nxt.prdata  = (pwrite || !mapped) ? 32'h00000000 : rd_word;
            st_nxt.pslverr = ~mapped;
        end else begin
            st_nxt.prdata  = 32'h00000000;
            st_nxt.pslverr = 1'b0;
        end
        if (wr && hit_cfg && pstrb[0]) begin
            st_nxt.cfg = sbff_cfg_t'(pwdata[2:0]);
        end
        if (wr && hit_bp && pstrb[0]) begin
            st_nxt.byte_pointer = pwdata[1:0];
        end
        if (wr && hit_a) begin
            st_nxt.oper_a = (st_r.oper_a & ~wmask) | (pwdata & wmask);
        end
        if (wr && hit_b) begin
            st_nxt.oper_b = (st_r.oper_b & ~wmask) | (pwdata & wmask);
        end
        if (res_en) begin
            st_nxt.result    = res_v;
            st_nxt.result_lo = res_lo_v;
        end
        // a set in the same cycle as a clear survives
        st_nxt.stat = (live_en ? live_v : st_r.stat) & ~clr_v | set_v;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.pready       <= 1'b0;
            st_r.pslverr      <= 1'b0;
            st_r.prdata       <= `SBFF_WORD_RESET;
            st_r.cfg          <= sbff_cfg_t'(`SBFF_CFG_RESET);
            st_r.byte_pointer <= `SBFF_BP_RESET;
            st_r.oper_a       <= `SBFF_WORD_RESET;
            st_r.oper_b       <= `SBFF_WORD_RESET;
            st_r.result       <= `SBFF_WORD_RESET;
            st_r.result_lo    <= `SBFF_WORD_RESET;
            st_r.stat         <= sbff_stat_t'(`SBFF_STAT_RESET);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata         = st_r.prdata;
    assign pready         = st_r.pready;
    assign pslverr        = st_r.pslverr;
    assign fp_emulate_req = st_r.stat.fp_emulate;
    assign fp_exc_trap    = st_r.stat.fp_exc_trap;

endmodule : sbff_unit

// ---- logic/sbff_params.svh ----
// offsets, field positions, reset values and opcodes of the subword unit
`ifndef SBFF_PARAMS_SVH
`define SBFF_PARAMS_SVH
`define SBFF_OFF_CONFIG     8'h00
`define SBFF_OFF_BYTE_PTR   8'h04
`define SBFF_OFF_OPER_A     8'h08
`define SBFF_OFF_OPER_B     8'h0c
`define SBFF_OFF_COMMAND    8'h10
`define SBFF_OFF_RESULT     8'h14
`define SBFF_OFF_STATUS     8'h18
`define SBFF_OFF_RESULT_LO  8'h1c
`define SBFF_CFG_RESET      3'h0
`define SBFF_BP_RESET       2'h0
`define SBFF_WORD_RESET     32'h00000000
`define SBFF_STAT_RESET     9'h000
`define SBFF_STICKY_MASK    9'h062
`define SBFF_OP_NOP         4'h0
`define SBFF_OP_EXTRACT_BYTE_OP      4'h1
`define SBFF_OP_INSERT_BYTE_OP      4'h2
`define SBFF_OP_COMPARE_BYTES_OP      4'h3
`define SBFF_OP_EXHALF      4'h4
`define SBFF_OP_EXHALF_S    4'h5
`define SBFF_OP_INHALF      4'h6
`define SBFF_OP_STORE_B     4'h7
`define SBFF_OP_STORE_H     4'h8
`define SBFF_OP_LOAD_B      4'h9
`define SBFF_OP_LOAD_H      4'ha
`define SBFF_OP_FP_SINGLE   4'hb
`define SBFF_OP_FP_DOUBLE   4'hc
`define SBFF_OP_BRANCH      4'hd
`define SBFF_SP_EXP_ONES    8'hff
`define SBFF_DP_EXP_ONES    11'h7ff
`define SBFF_SP_GEN_NAN     32'h7fe00000
`define SBFF_DP_GEN_NAN_HI  32'h7ffc0000
`define SBFF_DP_GEN_NAN_LO  32'h00000000
`endif

// ---- logic/sbff_pkg.sv ----
// types of the subword, boolean and float format unit
package sbff_pkg;
    typedef struct packed {
        logic fp_trap_en;
        logic data_width_enable;
        logic byte_order_select;
    } sbff_cfg_t;

    typedef struct packed {
        logic pair_misaligned;
        logic branch_true;
        logic fp_exc_trap;
        logic invalid_op;
        logic signaling;
        logic quiet;
        logic is_nan;
        logic fp_emulate;
        logic done;
    } sbff_stat_t;

    typedef struct packed {
        logic [7:0] pair_reg;
        logic [7:0] imm_byte;
        logic       invalid_req;
        logic       imm_sel;
        logic       sign_flag;
        logic [3:0] opcode;
    } sbff_cmd_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        sbff_cfg_t   cfg;
        logic [1:0]  byte_pointer;
        logic [31:0] oper_a;
        logic [31:0] oper_b;
        logic [31:0] result;
        logic [31:0] result_lo;
        sbff_stat_t  stat;
    } sbff_state_t;
endpackage : sbff_pkg

// ---- testbench/sbff_unit_asserts.sv ----
// port checker for the subword unit: apb timing and float flag causes
`timescale 1ns/1ps
module sbff_unit_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fp_emulate_req,
    input wire logic        fp_exc_trap
);
    logic cmd_fp;
    logic clr_emu;
    // status may land one cycle after the command edge, so both depths are allowed
    assign cmd_fp = pready && pwrite && paddr == 8'h10 && pstrb[0]
                    && (pwdata[3:0] == 4'hb || pwdata[3:0] == 4'hc);
    assign clr_emu = pready && pwrite && paddr == 8'h18 && pwdata[1];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_RDY_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not two cycles after setup");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    AST_UNMAP: assert property (pready && (paddr > 8'h1c || paddr[1:0] != 2'h0)
                                |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    AST_CMD_RD0: assert property (pready && !pwrite && paddr == 8'h10 |-> prdata == 32'h0)
        else $error("command register read nonzero");
    AST_EMU_CAUSE: assert property ($rose(fp_emulate_req) |-> $past(cmd_fp) || $past(cmd_fp, 2))
        else $error("emulation request without float command");
    AST_EMU_HOLD: assert property ($fell(fp_emulate_req) |-> $past(clr_emu) || $past(clr_emu, 2))
        else $error("emulation request dropped without clear");
    AST_TRAP_CAUSE: assert property ($rose(fp_exc_trap)
                                     |-> fp_emulate_req && ($past(cmd_fp) || $past(cmd_fp, 2)))
        else $error("trap without float command");

    cover property (pready && pslverr);
    cover property ($rose(fp_exc_trap));
    cover property ($fell(fp_emulate_req));
endmodule : sbff_unit_asserts

bind sbff_unit sbff_unit_asserts i_sbff_unit_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fp_emulate_req(fp_emulate_req), .fp_exc_trap(fp_exc_trap)
);

// ---- testbench/sbff_decode_model.sv ----
// apb master standing in for instruction decode and the register file
`timescale 1ns/1ps
module sbff_decode_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req,
    input  wire logic        req_wr,
    input  wire logic [7:0]  req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic             ack,
    output logic [31:0]      ack_rdata,
    output logic             ack_err
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel      <= 1'b0;
            penable   <= 1'b0;
            pwrite    <= 1'b0;
            paddr     <= 8'h00;
            pwdata    <= 32'h00000000;
            ack       <= 1'b0;
            ack_rdata <= 32'h00000000;
            ack_err   <= 1'b0;
        end else begin
            ack <= 1'b0;
            if (psel && penable && pready) begin
                psel      <= 1'b0;
                penable   <= 1'b0;
                // released data bus flips so a stale word is never read as fresh
                pwdata    <= ~pwdata;
                ack       <= 1'b1;
                ack_rdata <= prdata;
                ack_err   <= pslverr;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (req) begin
                psel   <= 1'b1;
                pwrite <= req_wr;
                paddr  <= req_addr;
                pwdata <= req_wdata;
            end
        end
    end
endmodule : sbff_decode_model

// ---- testbench/sbff_unit_tb.sv ----
// self-checking bench: register sequences through the decode model
`timescale 1ns/1ps
`include "sbff_params.svh"
module sbff_unit_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        req = 1'b0;
    logic        req_wr = 1'b0;
    logic [7:0]  req_addr = 8'h00;
    logic [31:0] req_wdata = 32'h0;
    logic        psel, penable, pwrite, pready, pslverr, ack, ack_err;
    logic        fp_emulate_req, fp_exc_trap;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, ack_rdata;
    int          fails = 0;
    int          tests_run = 0;

    always #12.5 pclk = ~pclk;

    sbff_decode_model i_sbff_decode_model (.pclk(pclk), .presetn(presetn), .req(req),
        .req_wr(req_wr), .req_addr(req_addr), .req_wdata(req_wdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .ack(ack), .ack_rdata(ack_rdata), .ack_err(ack_err));
    sbff_unit i_sbff_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fp_emulate_req(fp_emulate_req),
        .fp_exc_trap(fp_exc_trap));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req       <= 1'b1;
        req_wr    <= w;
        req_addr  <= a;
        req_wdata <= d;
        @(posedge pclk);
        req <= 1'b0;
        do begin
            @(negedge pclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(ack_rdata, exp);
    endtask : rd

    // clears sticky status, loads operands, fires the command, checks the result word
    task automatic run(input logic [31:0] cfg, input logic [31:0] bp, input logic [31:0] a,
                       input logic [31:0] b, input logic [31:0] cmd, input logic [31:0] exp);
        wr(`SBFF_OFF_STATUS, 32'h1ff);
        wr(`SBFF_OFF_CONFIG, cfg);
        wr(`SBFF_OFF_BYTE_PTR, bp);
        wr(`SBFF_OFF_OPER_A, a);
        wr(`SBFF_OFF_OPER_B, b);
        wr(`SBFF_OFF_COMMAND, cmd);
        rd(`SBFF_OFF_RESULT, exp);
    endtask : run

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SBFF_OFF_CONFIG, 32'h0);
        rd(`SBFF_OFF_STATUS, 32'h0);
        rd(`SBFF_OFF_COMMAND, 32'h0);
        rd(8'h20, 32'h0);
        chk({31'h0, ack_err}, 32'h1);
        wr(8'h22, 32'h7);
        rd(`SBFF_OFF_CONFIG, 32'h0);
        run(0, 2, 32'h11223344, 32'haabbccdd, 32'h1, 32'haabbcc22);
        run(1, 2, 32'h11223344, 32'haabbccdd, 32'h1, 32'haabbcc33);
        run(1, 0, 32'h11223344, 32'h0, 32'h1, 32'h00000011);
        run(0, 1, 32'h11223344, 32'h000000ee, 32'h2, 32'h1122ee44);
        run(0, 3, 32'h11223344, 32'h0, 32'h5a22, 32'h5a223344);
        run(0, 0, 32'h11223344, 32'h99229988, 32'h3, 32'h80000000);
        run(0, 0, 32'h11223344, 32'h00000044, 32'h3, 32'h80000000);
        run(0, 0, 32'h11223344, 32'h01020304, 32'h3, 32'h00000000);
        run(0, 2, 32'h11223344, 32'haabbccdd, 32'h4, 32'haabb1122);
        run(1, 2, 32'h11223344, 32'haabbccdd, 32'h4, 32'haabb3344);
        run(0, 2, 32'h80011234, 32'haabbccdd, 32'h5, 32'hffff8001);
        run(0, 0, 32'h80011234, 32'haabbccdd, 32'h5, 32'h00001234);
        run(0, 0, 32'h11223344, 32'h0000beef, 32'h6, 32'h1122beef);
        run(0, 2, 32'h11223344, 32'h0000beef, 32'h6, 32'hbeef3344);
        run(2, 0, 32'h123456a5, 32'h0, 32'h7, 32'ha5a5a5a5);
        run(0, 0, 32'h123456a5, 32'h0, 32'h7, 32'h123456a5);
        run(2, 0, 32'h123456a5, 32'h0, 32'h8, 32'h56a556a5);
        run(2, 1, 32'h0, 32'h1122b344, 32'h19, 32'hffffffb3);
        run(2, 1, 32'h0, 32'h1122b344, 32'h09, 32'h000000b3);
        run(2, 0, 32'h0, 32'h1122b344, 32'h1a, 32'hffffb344);
        run(0, 0, 32'h0, 32'h1122b344, 32'h0a, 32'h1122b344);
        run(0, 0, 32'h80000000, 32'h0, 32'hd, 32'h1122b344);
        rd(`SBFF_OFF_STATUS, 32'h81);
        run(0, 0, 32'h7fffffff, 32'h0, 32'hd, 32'h1122b344);
        rd(`SBFF_OFF_STATUS, 32'h01);
        run(4, 0, 32'h7f800001, 32'h0, 32'hb, 32'h7fe00000);
        rd(`SBFF_OFF_STATUS, 32'h77);
        chk({30'h0, fp_exc_trap, fp_emulate_req}, 32'h3);
        run(0, 0, 32'hffc00001, 32'h0, 32'hb, 32'h7fe00000);
        rd(`SBFF_OFF_STATUS, 32'h0f);
        chk({31'h0, fp_exc_trap}, 32'h0);
        run(4, 0, 32'h7f800000, 32'h3f800000, 32'hb, 32'h7fe00000);
        rd(`SBFF_OFF_STATUS, 32'h03);
        run(0, 0, 32'h0, 32'h0, 32'h4b, 32'h7fe00000);
        rd(`SBFF_OFF_STATUS, 32'h23);
        run(0, 0, 32'h7ff00000, 32'h1, 32'h2000c, 32'h7ffc0000);
        rd(`SBFF_OFF_RESULT_LO, 32'h0);
        rd(`SBFF_OFF_STATUS, 32'h37);
        run(0, 0, 32'h7ff00000, 32'h1, 32'h3000c, 32'h7ffc0000);
        rd(`SBFF_OFF_STATUS, 32'h137);
        wr(`SBFF_OFF_STATUS, 32'h1ff);
        @(negedge pclk);
        @(negedge pclk);
        chk({31'h0, fp_emulate_req}, 32'h0);
        wrap_up();
    end
endmodule : sbff_unit_tb
